// File: usb_event_flags.sv
/*
 * event and status flags of a usb function controller, the port b direction
 * register that steers the bus pull-up pin, and an axi4-lite register slave.
 * assumes the packet engine and endpoint fifos give one-cycle event pulses and
 * fifo levels synchronous to mclk, and vbus already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none

module usb_event_flags
   import usb_event_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // axi4-lite write
   input wire logic [usb_event_flags_pkg::AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [usb_event_flags_pkg::AXI_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [usb_event_flags_pkg::AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [usb_event_flags_pkg::AXI_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // events from the packet engine
   input wire logic busResetDet,
   input wire logic epInfoDone,
   input wire logic setConfigDet,
   input wire logic setInterfaceDet,
   input wire logic frameStartDet,
   input wire logic setupDone,
   input wire logic ctrlOutDone,
   input wire logic ctrlInReq,
   input wire logic ctrlInDone,
   input wire logic epCReq,
   input wire logic epCDone,
   input wire logic epBReq,
   // levels from the fifos and the cable
   input wire logic vbus,
   input wire logic epBTxEmpty,
   input wire logic epBAllEmpty,
   input wire logic epAFull,
   // pull-up control pin
   output logic pullupOut,
   output logic pullupOe_b,
   // interrupt requests, one per flag group
   output logic [2:0] flagIrq
);
   import usb_event_flags_pkg::*;

   // ********************************************
   // state
   // ********************************************
   typedef struct packed {
      logic awReady;
      logic wReady;
      logic [31:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [7:0] flags0;
      logic [7:0] flags1;
      logic [7:0] flags2;
      logic [15:0] direction;
      logic vbusLast;
      logic pullupOut;
      logic pullupOeB;
      logic [2:0] irq;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic wrDo;
   logic [7:0] clr0;
   logic [7:0] clr1;
   logic [7:0] clr2;

   // ********************************************
   // helpers
   // ********************************************
   function automatic regsel_t decode(input logic [31:0] addr);
      regsel_t sel;
      sel = SEL_NONE;
      if (addr[31:2] == ADDR_PORT_B_DIRECTION_LOW[31:2]) begin
         sel = SEL_DIR;
      end else if (addr[31:2] == ADDR_USB_EVENT_FLAGS_ZERO[31:2]) begin
         sel = SEL_F0;
      end else if (addr[31:2] == ADDR_USB_EVENT_FLAGS_ONE[31:2]) begin
         sel = SEL_F1;
      end else if (addr[31:2] == ADDR_USB_EVENT_FLAGS_TWO[31:2]) begin
         sel = SEL_F2;
      end
      return sel;
   endfunction

   // set wins over clear, so an event landing on a clear write survives
   function automatic logic [7:0] flagNext(input logic [7:0] cur, input logic [7:0] set,
                                           input logic [7:0] clr, input logic [7:0] sticky,
                                           input logic [7:0] level);
      return (((cur & ~clr) | set) & sticky) | (level & ~sticky);
   endfunction

   function automatic logic [7:0] ev(input logic hit, input logic [7:0] mask);
      return hit ? mask : 8'h00;
   endfunction

   // ********************************************
   // next state
   // ********************************************
   always_comb begin
      state_next = state_reg;
      wrDo = !state_reg.awReady && !state_reg.wReady && !state_reg.bValid;
      clr0 = 8'h00;
      clr1 = 8'h00;
      clr2 = 8'h00;

      // write channel: address and data taken in either order
      if (awvalid && state_reg.awReady) begin
         state_next.awReady = 1'b0;
         state_next.awAddr = awaddr;
      end
      if (wvalid && state_reg.wReady) begin
         state_next.wReady = 1'b0;
         state_next.wData = wdata;
         state_next.wStrb = wstrb;
      end
      if (wrDo) begin
         state_next.bValid = 1'b1;
         state_next.bResp = RESP_OKAY;
         case (decode(state_reg.awAddr))
            SEL_DIR: begin
               if (state_reg.wStrb[0]) begin
                  state_next.direction[7:0] = state_reg.wData[7:0];
               end
               if (state_reg.wStrb[1]) begin
                  state_next.direction[15:8] = state_reg.wData[15:8];
               end
            end
            // write one to clear; sticky bits only
            SEL_F0: clr0 = state_reg.wStrb[0] ? state_reg.wData[7:0] : 8'h00;
            SEL_F1: clr1 = state_reg.wStrb[0] ? state_reg.wData[7:0] : 8'h00;
            SEL_F2: clr2 = state_reg.wStrb[0] ? state_reg.wData[7:0] : 8'h00;
            default: state_next.bResp = RESP_SLVERR;
         endcase
      end
      // readies come back only after the response, one write at a time
      if (state_reg.bValid && bready) begin
         state_next.bValid = 1'b0;
         state_next.awReady = 1'b1;
         state_next.wReady = 1'b1;
      end

      // read channel
      if (arvalid && state_reg.arReady) begin
         state_next.arReady = 1'b0;
         state_next.rValid = 1'b1;
         state_next.rResp = RESP_OKAY;
         case (decode(araddr))
            SEL_DIR: state_next.rData = {16'h0000, state_reg.direction};
            SEL_F0: state_next.rData = {24'h000000, state_reg.flags0};
            SEL_F1: state_next.rData = {24'h000000, state_reg.flags1};
            SEL_F2: state_next.rData = {24'h000000, state_reg.flags2};
            default: begin
               state_next.rData = 32'h00000000;
               state_next.rResp = RESP_SLVERR;
            end
         endcase
      end
      if (state_reg.rValid && rready) begin
         state_next.rValid = 1'b0;
         state_next.arReady = 1'b1;
      end

      // flag group zero
      state_next.vbusLast = vbus;
      state_next.flags0 = flagNext(state_reg.flags0,
         ev(busResetDet, F0_BUS_RESET_SEEN)
         | ev(epInfoDone, F0_ENDPOINT_INFO_LOADED)
         | ev(setConfigDet, F0_CONFIG_REQUEST_SEEN)
         | ev(setInterfaceDet, F0_INTERFACE_REQUEST_SEEN)
         | ev(vbus != state_reg.vbusLast, F0_ATTACH_CHANGE),
         clr0, F0_STICKY,
         ev(vbus, F0_VBUS_LEVEL_MONITOR));

      // flag group one
      state_next.flags1 = flagNext(state_reg.flags1,
         ev(frameStartDet, F1_FRAME_START_SEEN)
         | ev(setupDone, F1_SETUP_RECEIVED)
         | ev(ctrlOutDone, F1_CTRL_OUT_RECEIVED)
         | ev(ctrlInReq, F1_CTRL_IN_REQUEST)
         | ev(ctrlInDone, F1_CTRL_IN_SENT),
         clr1, F1_STICKY, 8'h00);

      // flag group two; fifo bits follow the fifo levels
      state_next.flags2 = flagNext(state_reg.flags2,
         ev(epCReq, F2_EP_C_REQUEST)
         | ev(epCDone, F2_EP_C_SENT)
         | ev(epBReq, F2_EP_B_REQUEST),
         clr2, F2_STICKY,
         ev(epBTxEmpty, F2_EP_B_BUFFER_FREE)
         | ev(epBAllEmpty, F2_EP_B_ALL_FREE)
         | ev(epAFull, F2_EP_A_FULL));

      // requests follow the flags that the same edge stores
      state_next.irq = {|state_next.flags2, |state_next.flags1, |state_next.flags0};

      // pull-up pin driven high while it is an output
      state_next.pullupOut = state_next.direction[PULLUP_PIN_BIT];
      state_next.pullupOeB = !state_next.direction[PULLUP_PIN_BIT];
   end

   // ********************************************
   // registers
   // ********************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '{awReady: 1'b1, wReady: 1'b1, awAddr: 32'h00000000,
                        wData: 32'h00000000, wStrb: 4'h0, bValid: 1'b0, bResp: RESP_OKAY,
                        arReady: 1'b1, rValid: 1'b0, rData: 32'h00000000,
                        rResp: RESP_OKAY, flags0: FLAGS_RESET, flags1: FLAGS_RESET,
                        flags2: FLAGS_RESET, direction: DIRECTION_RESET, vbusLast: 1'b0,
                        pullupOut: 1'b0, pullupOeB: 1'b1, irq: 3'h0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign awready = state_reg.awReady;
   assign wready = state_reg.wReady;
   assign bvalid = state_reg.bValid;
   assign bresp = state_reg.bResp;
   assign arready = state_reg.arReady;
   assign rvalid = state_reg.rValid;
   assign rdata = state_reg.rData;
   assign rresp = state_reg.rResp;
   assign pullupOut = state_reg.pullupOut;
   assign pullupOe_b = state_reg.pullupOeB;
   assign flagIrq = state_reg.irq;

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   bus_reset_a: assert property (busResetDet |=> state_reg.flags0[7])
      else $error("bus reset flag not set");
   info_loaded_a: assert property (epInfoDone |=> state_reg.flags0[6])
      else $error("endpoint info flag not set");
   set_config_a: assert property (setConfigDet |=> state_reg.flags0[3])
      else $error("configuration flag not set");
   set_iface_a: assert property (setInterfaceDet |=> state_reg.flags0[2])
      else $error("interface flag not set");
   vbus_level_a: assert property (##1 state_reg.flags0[1] == $past(vbus))
      else $error("vbus monitor does not follow pin");
   attach_edge_a: assert property ($changed(vbus) |-> ##1 state_reg.flags0[0])
      else $error("attach change missed");
   frame_start_a: assert property (frameStartDet |=> state_reg.flags1[4])
      else $error("frame start flag not set");
   setup_done_a: assert property (setupDone |=> state_reg.flags1[3])
      else $error("setup flag not set");
   ctrl_in_a: assert property (ctrlInReq |=> state_reg.flags1[1])
      else $error("control-in request flag not set");
   ctrl_sent_a: assert property (ctrlInDone |=> state_reg.flags1[0])
      else $error("control-in sent flag not set");
   ctrl_out_a: assert property (ctrlOutDone |=> state_reg.flags1[2])
      else $error("control-out flag not set");
   ep_c_req_a: assert property (epCReq |=> state_reg.flags2[5])
      else $error("endpoint three request flag not set");
   ep_c_sent_a: assert property (epCDone |=> state_reg.flags2[4])
      else $error("endpoint three sent flag not set");
   ep_b_req_a: assert property (epBReq |=> state_reg.flags2[3])
      else $error("endpoint two request flag not set");
   fifo_levels_a: assert property (##1 state_reg.flags2[2:0]
                                   == $past({epBTxEmpty, epBAllEmpty, epAFull}))
      else $error("fifo level bits wrong");
   pullup_dir_a: assert property (##1 pullupOe_b == !$past(state_next.direction[15]))
      else $error("pull-up enable does not follow direction");
   dir_write_a: assert property (wrDo && decode(state_reg.awAddr) == SEL_DIR
                                 && state_reg.wStrb[1]
                                 |=> state_reg.direction[15] == $past(state_reg.wData[15]))
      else $error("direction bit not written");
   flag_hold_a: assert property (state_reg.flags1[2] && !(wrDo && clr1[2])
                                 |=> state_reg.flags1[2])
      else $error("flag lost without a clear");
   sticky_two_a: assert property (state_reg.flags2[5] && !(wrDo && clr2[5])
                                  |=> state_reg.flags2[5])
      else $error("endpoint flag lost without a clear");
   set_beats_clr_a: assert property (wrDo && clr0[7] && busResetDet
                                     |=> state_reg.flags0[7])
      else $error("event lost during clear");
   clear_works_a: assert property (wrDo && clr1[4] && !frameStartDet
                                   |=> !state_reg.flags1[4])
      else $error("flag not cleared by write");
   no_spurious_a: assert property (!state_reg.flags0[7] && !busResetDet
                                   |=> !state_reg.flags0[7])
      else $error("bus reset flag set without event");
   attach_quiet_a: assert property ($stable(vbus) && $past(rst_b)
                                    && !state_reg.flags0[0] |=> !state_reg.flags0[0])
      else $error("attach change without vbus change");
   irq_zero_a: assert property (flagIrq[0] == (state_reg.flags0 != 8'h00))
      else $error("group zero interrupt does not match flags");
   irq_one_a: assert property (flagIrq[1] == (state_reg.flags1 != 8'h00))
      else $error("group one interrupt does not match flags");
   irq_group_a: assert property (flagIrq[2] == (state_reg.flags2 != 8'h00))
      else $error("interrupt does not match flags");

   // ********************************************
   // register bus checks
   // ********************************************
   bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before ready");
   rvalid_hold_a: assert property (rvalid && !rready
                                   |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped before ready");
   write_busy_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   read_busy_a: assert property (rvalid |-> !arready)
      else $error("read taken while data pending");
   write_answer_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
      else $error("write response late");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   write_err_a: assert property (wrDo && decode(state_reg.awAddr) == SEL_NONE
                                 |=> bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   read_err_a: assert property (arvalid && arready && decode(araddr) == SEL_NONE
                                |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
      else $error("unmapped read not refused");
   read_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("unused read bits not zero");

   write_done_c: cover property (awvalid && awready ##[1:4] bvalid && bready);
   read_done_c: cover property (arvalid && arready ##1 rvalid && rready);
   clear_race_c: cover property (wrDo && clr0[7] && busResetDet);
   pullup_on_c: cover property (!pullupOe_b && pullupOut);
   attach_c: cover property ($rose(vbus));

endmodule

`default_nettype wire

// File: usb_event_flags_pkg.sv
/*
 * constants for the usb function event flag block: register indices and byte
 * addresses, flag masks, reset values and bus response codes.
 * assumes a 32-bit axi4-lite register bus and one word per register.
 */
`default_nettype none

package usb_event_flags_pkg;

   // ********************************************
   // bus shape
   // ********************************************
   localparam int AXI_AW = 32;
   localparam int AXI_DW = 32;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ********************************************
   // register indices, byte address is four times the index
   // ********************************************
   localparam logic [31:0] IDX_PORT_B_DIRECTION_LOW = 32'hfffe3886;
   localparam logic [31:0] IDX_USB_EVENT_FLAGS_ZERO = 32'hfffe7000;
   localparam logic [31:0] IDX_USB_EVENT_FLAGS_ONE = 32'hfffe7001;
   localparam logic [31:0] IDX_USB_EVENT_FLAGS_TWO = 32'hfffe7002;
   localparam logic [31:0] ADDR_PORT_B_DIRECTION_LOW = {IDX_PORT_B_DIRECTION_LOW[29:0], 2'b00};
   localparam logic [31:0] ADDR_USB_EVENT_FLAGS_ZERO = {IDX_USB_EVENT_FLAGS_ZERO[29:0], 2'b00};
   localparam logic [31:0] ADDR_USB_EVENT_FLAGS_ONE = {IDX_USB_EVENT_FLAGS_ONE[29:0], 2'b00};
   localparam logic [31:0] ADDR_USB_EVENT_FLAGS_TWO = {IDX_USB_EVENT_FLAGS_TWO[29:0], 2'b00};

   // ********************************************
   // flag masks
   // ********************************************
   localparam logic [7:0] F0_BUS_RESET_SEEN = 8'h80;
   localparam logic [7:0] F0_ENDPOINT_INFO_LOADED = 8'h40;
   localparam logic [7:0] F0_CONFIG_REQUEST_SEEN = 8'h08;
   localparam logic [7:0] F0_INTERFACE_REQUEST_SEEN = 8'h04;
   localparam logic [7:0] F0_VBUS_LEVEL_MONITOR = 8'h02;
   localparam logic [7:0] F0_ATTACH_CHANGE = 8'h01;
   localparam logic [7:0] F1_FRAME_START_SEEN = 8'h10;
   localparam logic [7:0] F1_SETUP_RECEIVED = 8'h08;
   localparam logic [7:0] F1_CTRL_OUT_RECEIVED = 8'h04;
   localparam logic [7:0] F1_CTRL_IN_REQUEST = 8'h02;
   localparam logic [7:0] F1_CTRL_IN_SENT = 8'h01;
   localparam logic [7:0] F2_EP_C_REQUEST = 8'h20;
   localparam logic [7:0] F2_EP_C_SENT = 8'h10;
   localparam logic [7:0] F2_EP_B_REQUEST = 8'h08;
   localparam logic [7:0] F2_EP_B_BUFFER_FREE = 8'h04;
   localparam logic [7:0] F2_EP_B_ALL_FREE = 8'h02;
   localparam logic [7:0] F2_EP_A_FULL = 8'h01;
   localparam logic [7:0] F0_STICKY = 8'hcd;
   localparam logic [7:0] F1_STICKY = 8'h1f;
   localparam logic [7:0] F2_STICKY = 8'h38;
   localparam logic [15:0] PULLUP_PIN_DIRECTION = 16'h8000;
   localparam int PULLUP_PIN_BIT = 15;

   // ********************************************
   // reset values
   // ********************************************
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] DIRECTION_RESET = 16'h0000;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_DIR = 3'b001,
      SEL_F0 = 3'b011,
      SEL_F1 = 3'b010,
      SEL_F2 = 3'b110
   } regsel_t;

endpackage

`default_nettype wire

// File: usb_event_flags_tb.sv
/*
 * self-checking bench: axi4-lite tasks, event table, level flags,
 * sticky clears and the pull-up pin.
 * assumes the package and usb_host_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module usb_event_flags_tb;
   import usb_event_flags_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pullupOut, pullupOe_b;
   logic [1:0] bresp, rresp;
   logic [2:0] flagIrq;
   logic [11:0] evReq = 12'h0, ev;
   logic cableIn = 1'b0, vbus;
   logic [2:0] lvl = 3'b000;
   int badCount = 0, nCompared = 0;
   localparam logic [7:0] EVM [12] = '{F0_BUS_RESET_SEEN, F0_ENDPOINT_INFO_LOADED,
      F0_CONFIG_REQUEST_SEEN, F0_INTERFACE_REQUEST_SEEN, F1_FRAME_START_SEEN,
      F1_SETUP_RECEIVED, F1_CTRL_OUT_RECEIVED, F1_CTRL_IN_REQUEST, F1_CTRL_IN_SENT,
      F2_EP_C_REQUEST, F2_EP_C_SENT, F2_EP_B_REQUEST};
   localparam logic [31:0] FA [3] = '{ADDR_USB_EVENT_FLAGS_ZERO, ADDR_USB_EVENT_FLAGS_ONE,
      ADDR_USB_EVENT_FLAGS_TWO};
   localparam logic [31:0] DA = ADDR_PORT_B_DIRECTION_LOW;
   localparam logic [31:0] BAD = ADDR_USB_EVENT_FLAGS_TWO + 32'h4;

   usb_host_model host (.mclk(mclk), .rst_b(rst_b), .evReq(evReq), .cableIn(cableIn),
      .ev(ev), .vbus(vbus));
   usb_event_flags uut (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .busResetDet(ev[0]), .epInfoDone(ev[1]), .setConfigDet(ev[2]),
      .setInterfaceDet(ev[3]), .frameStartDet(ev[4]), .setupDone(ev[5]),
      .ctrlOutDone(ev[6]), .ctrlInReq(ev[7]), .ctrlInDone(ev[8]), .epCReq(ev[9]),
      .epCDone(ev[10]), .epBReq(ev[11]), .vbus(vbus), .epBTxEmpty(lvl[2]),
      .epBAllEmpty(lvl[1]), .epAFull(lvl[0]), .pullupOut(pullupOut),
      .pullupOe_b(pullupOe_b), .flagIrq(flagIrq));

   initial begin
      forever #5 mclk = ~mclk;
   end

   // ********************************************
   // checking and closing
   // ********************************************
   task automatic summarize();
      $display("compared %0d mismatched %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic giveUp();
      badCount++;
      $display("[FAIL] bus answer expected within 50 cycles seen none");
      summarize();
   endtask

   // ********************************************
   // axi4-lite master, no assumed latency
   // ********************************************
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) giveUp();
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) giveUp();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rdChk(input logic [31:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      chk(what, exp, d);
      chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask

   task automatic pulse(input int i);
      @(posedge mclk);
      evReq <= 12'h001 << i;
      @(posedge mclk);
      evReq <= 12'h000;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // ********************************************
   // scenarios
   // ********************************************
   task automatic testBus();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 3; i++) begin
         rdChk(FA[i], 32'h0, "flags reset");
      end
      rdChk(DA, 32'h0, "direction reset");
      axiRead(BAD, d, r);
      chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped read data", 32'h0, d);
      axiWrite(BAD, 32'hffff_ffff, r);
      chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axiWrite(DA, 32'h7fff, r);
      #1;
      chk("pin released", 32'h1, {31'h0, pullupOe_b});
      axiWrite(DA, 32'hffff_ffff, r);
      #1;
      chk("pin driven", 32'h0, {31'h0, pullupOe_b});
      chk("pin level", 32'h1, {31'h0, pullupOut});
      rdChk(DA, 32'hffff, "direction readback");
      axiWrite(DA, 32'h0, r);
      #1;
      chk("pin released", 32'h1, {31'h0, pullupOe_b});
      axiWrite(DA, {16'h0, PULLUP_PIN_DIRECTION}, r);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      #1;
      chk("pin driven", 32'h0, {31'h0, pullupOe_b});
   endtask

   task automatic testEvents();
      logic [1:0] r;
      int g;
      for (int i = 0; i < 12; i++) begin
         g = (i < 4) ? 0 : ((i < 9) ? 1 : 2);
         pulse(i);
         chk("group irq", 32'h1 << g, {29'h0, flagIrq});
         if (g == 0) rdChk(FA[g], {24'h0, EVM[i]}, "event flag");
         if (g == 1) rdChk(FA[g], {24'h0, EVM[i]}, "event flag");
         if (g == 2) rdChk(FA[g], {24'h0, EVM[i]}, "event flag");
         axiWrite(FA[g], {24'h0, EVM[i]}, r);
         rdChk(FA[g], 32'h0, "flag cleared");
         chk("group irq", 32'h0, {29'h0, flagIrq});
      end
   endtask

   task automatic testHold();
      logic [1:0] r;
      @(posedge mclk);
      evReq <= 12'h010;
      repeat (3) @(posedge mclk);
      axiWrite(FA[1], 32'h10, r);
      rdChk(FA[1], 32'h10, "set beats clear");
      evReq <= 12'h000;
      repeat (3) @(posedge mclk);
      rdChk(FA[1], 32'h10, "flag sticks");
      axiWrite(FA[1], 32'h10, r);
      rdChk(FA[1], 32'h0, "flag cleared");
   endtask

   task automatic testLevels();
      logic [1:0] r;
      @(posedge mclk);
      cableIn <= 1'b1;
      repeat (3) @(posedge mclk);
      rdChk(FA[0], 32'h3, "attach");
      axiWrite(FA[0], 32'h3, r);
      rdChk(FA[0], 32'h2, "vbus kept");
      chk("level irq", 32'h1, {29'h0, flagIrq});
      cableIn <= 1'b0;
      repeat (3) @(posedge mclk);
      rdChk(FA[0], 32'h1, "detach");
      axiWrite(FA[0], 32'h1, r);
      lvl <= 3'b100;
      repeat (3) @(posedge mclk);
      rdChk(FA[2], 32'h4, "tx empty");
      lvl <= 3'b011;
      repeat (3) @(posedge mclk);
      rdChk(FA[2], 32'h3, "all empty, full");
      axiWrite(FA[2], 32'h7, r);
      rdChk(FA[2], 32'h3, "level ignores clear");
      chk("level irq", 32'h4, {29'h0, flagIrq});
      lvl <= 3'b000;
      repeat (3) @(posedge mclk);
      rdChk(FA[2], 32'h0, "levels gone");
      rdChk(FA[0], 32'h0, "attach cleared");
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      testBus();
      $display("bus test done");
      testEvents();
      $display("event test done");
      testHold();
      $display("hold test done");
      testLevels();
      $display("level test done");
      summarize();
   end

   initial begin
      repeat (50000) @(posedge mclk);
      badCount++;
      summarize();
   end
endmodule
`default_nettype wire

// File: usb_host_model.sv
/*
 * far side of the usb function: turns bench requests into packet engine
 * event strobes and the cable's vbus level.
 * assumes requests change just after a rising edge of mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // requests from the bench
   input wire logic [11:0] evReq,
   input wire logic cableIn,
   // packet engine and cable
   output logic [11:0] ev,
   output logic vbus
);
   // ********************************************
   // registered, as a real engine delays its decode
   // ********************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ev <= 12'h000;
         vbus <= 1'b0;
      end else begin
         ev <= evReq;
         vbus <= cableIn;
      end
   end
endmodule
`default_nettype wire
